/* design/power_down_entry_defs.svh */
// Constants for the power-down entry control block.
// Assumes one 125 MHz core clock and synchronous pin inputs.
`ifndef POWER_DOWN_ENTRY_DEFS_SVH
`define POWER_DOWN_ENTRY_DEFS_SVH
`define WAKE_PIN_COUNT 8
`define SEL_NMI 1'b0
`define SEL_PORT2 1'b1
`define WAIT_BIT_TRISTATE 1'b0
`endif

/* design/power_down_entry_pkg.sv */
// Types for the power-down entry control block.
// Assumes the defs header is on the include path.
`include "power_down_entry_defs.svh"
package power_down_entry_pkg;
  typedef enum logic [2:0] {
    RUN = 3'b001,
    QUASI_IDLE = 3'b010,
    POWER_DOWN = 3'b100
  } pd_state_t;
  typedef struct packed {
    logic wakeSourceSelect;
    logic [`WAKE_PIN_COUNT-1:0] wakeEnable;
    logic [`WAKE_PIN_COUNT-1:0] wakeActiveHigh;
    logic multiplexedBus;
    logic memoryTristateWaitBit;
  } pd_config_t;
endpackage : power_down_entry_pkg

/* design/power_down_entry_control.sv */
// Decides whether a power-down instruction enters power-down.
// Assumes the CPU pulses the instruction strobe for one cycle and that
// all pins and configuration are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "power_down_entry_defs.svh"
module power_down_entry_control
  import power_down_entry_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Instruction stream
  input wire logic powerDownInstruction,
  input wire logic prevExternalWrite,
  input wire logic nextCodeExternal,
  // Configuration and pins
  input wire pd_config_t sysConfig,
  input wire logic nmiPin,
  input wire logic [`WAKE_PIN_COUNT-1:0] wakePins,
  // Peripheral events
  input wire logic watchdogOverflow,
  input wire logic interruptRequest,
  input wire logic eventTransferRequest,
  // Status
  output logic powerDownMode,
  output logic quasiIdle,
  output logic fetchEnable,
  output logic interruptGrant,
  output logic eventTransferGrant,
  output logic watchdogReset
);

  ////////////////////////////////////////////////////////////////////////
  pd_state_t state_reg, state_next;
  logic grantInt_reg, grantInt_next;
  logic grantPec_reg, grantPec_next;
  logic wdReset_reg, wdReset_next;
  logic [`WAKE_PIN_COUNT-1:0] wakeHit;
  logic wakeAsserted;
  logic ignoreEntry;
  logic quasiCause;

  // Per-pin active-level compare on enabled wake pins
  genvar i;
  generate
    for (i = 0; i < `WAKE_PIN_COUNT; i++) begin : g_wake
      assign wakeHit[i] = sysConfig.wakeEnable[i] & (wakePins[i] == sysConfig.wakeActiveHigh[i]);
    end
  endgenerate

  assign wakeAsserted = |wakeHit;
  assign ignoreEntry = (sysConfig.wakeSourceSelect == `SEL_NMI) ? nmiPin : wakeAsserted;
  // The fault path: an ignored instruction still stalls fetch on external code after an external write or on a multiplexed bus with tristate wait
  assign quasiCause = nextCodeExternal &
    ((sysConfig.multiplexedBus & (sysConfig.memoryTristateWaitBit == `WAIT_BIT_TRISTATE))
     | prevExternalWrite);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    // Watchdog reset takes priority over every state decision
    if (wdReset_reg) begin
      state_next = RUN;
    end else begin
    unique case (state_reg)
      RUN: begin
        if (powerDownInstruction) begin
          if (!ignoreEntry) begin
            state_next = POWER_DOWN;
          end else if (quasiCause) begin
            state_next = QUASI_IDLE;
          end
        end
      end
      QUASI_IDLE: begin
        if (!nmiPin) begin
          state_next = POWER_DOWN;
        end
      end
      POWER_DOWN: begin
        state_next = POWER_DOWN;
      end
      default: begin
        state_next = RUN;
      end
    endcase
    end
  end

  // Grants are suppressed outside normal run; watchdog acts in every state except power-down
  always_comb begin
    grantInt_next = interruptRequest & (state_next == RUN) & !wdReset_reg;
    grantPec_next = eventTransferRequest & (state_next == RUN) & !wdReset_reg;
    wdReset_next = watchdogOverflow & (state_reg != POWER_DOWN) & !wdReset_reg;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= RUN;
      grantInt_reg <= 1'b0;
      grantPec_reg <= 1'b0;
      wdReset_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      grantInt_reg <= grantInt_next;
      grantPec_reg <= grantPec_next;
      wdReset_reg <= wdReset_next;
    end
  end

  // One-hot codes let each status output be a single state flip-flop
  assign powerDownMode = state_reg[2];
  assign quasiIdle = state_reg[1];
  assign fetchEnable = state_reg[0];
  assign interruptGrant = grantInt_reg;
  assign eventTransferGrant = grantPec_reg;
  assign watchdogReset = wdReset_reg;

  ////////////////////////////////////////////////////////////////////////
  a_nmi_ignore: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg == RUN && powerDownInstruction && !sysConfig.wakeSourceSelect && nmiPin && !wdReset_reg)
    |=> !powerDownMode) else $error("entry not ignored with nmi high");
  a_wake_ignore: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg == RUN && powerDownInstruction && sysConfig.wakeSourceSelect && wakeAsserted && !wdReset_reg)
    |=> !powerDownMode) else $error("entry not ignored with wake pin active");
  a_normal_entry: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg == RUN && powerDownInstruction && !ignoreEntry && !wdReset_reg)
    |=> powerDownMode) else $error("normal power-down entry missed");
  a_mux_quasi: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg == RUN && powerDownInstruction && ignoreEntry && nextCodeExternal && sysConfig.multiplexedBus
     && !sysConfig.memoryTristateWaitBit && !wdReset_reg) |=> quasiIdle && !fetchEnable)
    else $error("quasi-idle not entered on multiplexed bus");
  a_write_quasi: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg == RUN && powerDownInstruction && ignoreEntry && nextCodeExternal && prevExternalWrite && !wdReset_reg)
    |=> quasiIdle) else $error("quasi-idle not entered after external write");
  a_quasi_watchdog: assert property (@(posedge core_clk) disable iff (reset)
    (quasiIdle && watchdogOverflow && !wdReset_reg) |=> watchdogReset ##1 fetchEnable)
    else $error("watchdog did not reset quasi-idle device");
  a_quasi_nogrant: assert property (@(posedge core_clk) disable iff (reset)
    quasiIdle[*2] |-> !interruptGrant && !eventTransferGrant)
    else $error("grant issued while quasi-idle");
  a_quasi_exit: assert property (@(posedge core_clk) disable iff (reset)
    (quasiIdle && !nmiPin && !wdReset_reg) |=> powerDownMode && !$past(powerDownMode))
    else $error("nmi low did not enter power-down");

  ////////////////////////////////////////////////////////////////////////
  // State and status consistency
  a_state_onehot: assert property (@(posedge core_clk) disable iff (reset)
    $onehot(state_reg))
    else $error("state register not one-hot");

  a_fetch_run: assert property (@(posedge core_clk) disable iff (reset)
    fetchEnable |-> !quasiIdle && !powerDownMode)
    else $error("fetch enabled outside run");

  a_quasi_nofetch: assert property (@(posedge core_clk) disable iff (reset)
    quasiIdle |-> !fetchEnable)
    else $error("fetch enabled while quasi-idle");

  a_pd_sticky: assert property (@(posedge core_clk) disable iff (reset)
    (powerDownMode && !watchdogReset) |=> powerDownMode)
    else $error("power-down left without reset");

  a_pd_entry: assert property (@(posedge core_clk) disable iff (reset)
    $rose(powerDownMode) |-> (($past(powerDownInstruction) && !$past(ignoreEntry))
    || ($past(quasiIdle) && !$past(nmiPin))))
    else $error("power-down entered without cause");

  a_quasi_entry: assert property (@(posedge core_clk) disable iff (reset)
    $rose(quasiIdle) |-> $past(powerDownInstruction) && $past(ignoreEntry) && $past(quasiCause))
    else $error("quasi-idle entered without cause");

  a_quasi_hold: assert property (@(posedge core_clk) disable iff (reset)
    (quasiIdle && nmiPin && !watchdogOverflow && !wdReset_reg) |=> quasiIdle)
    else $error("quasi-idle left without nmi or watchdog");

  a_strobe_refused: assert property (@(posedge core_clk) disable iff (reset)
    (quasiIdle && powerDownInstruction && nmiPin && !watchdogOverflow && !wdReset_reg) |=> quasiIdle)
    else $error("strobe acted while quasi-idle");

  a_ignored_run: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg == RUN && powerDownInstruction && ignoreEntry && !quasiCause && !wdReset_reg) |=> fetchEnable)
    else $error("ignored entry stopped fetch");

  a_ignored_noquasi: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg == RUN && powerDownInstruction && ignoreEntry && !quasiCause && !wdReset_reg) |=> !quasiIdle)
    else $error("quasi-idle without bus cause");

  ////////////////////////////////////////////////////////////////////////
  // Watchdog behaviour
  a_wd_pulse: assert property (@(posedge core_clk) disable iff (reset)
    watchdogReset |-> $past(watchdogOverflow))
    else $error("watchdog reset without overflow");

  a_wd_run: assert property (@(posedge core_clk) disable iff (reset)
    watchdogReset |=> fetchEnable && !watchdogReset)
    else $error("watchdog reset did not return to run");

  a_pd_nowatchdog: assert property (@(posedge core_clk) disable iff (reset)
    powerDownMode |=> !watchdogReset)
    else $error("watchdog acted in power-down");

  a_wd_clears_grant: assert property (@(posedge core_clk) disable iff (reset)
    watchdogReset |=> !interruptGrant && !eventTransferGrant)
    else $error("grant issued during watchdog reset");

  ////////////////////////////////////////////////////////////////////////
  // Grants
  a_grant_follow: assert property (@(posedge core_clk) disable iff (reset)
    interruptGrant |-> $past(interruptRequest))
    else $error("interrupt grant without request");

  a_pec_follow: assert property (@(posedge core_clk) disable iff (reset)
    eventTransferGrant |-> $past(eventTransferRequest))
    else $error("event transfer grant without request");

  a_int_quasi: assert property (@(posedge core_clk) disable iff (reset)
    quasiIdle |-> !interruptGrant)
    else $error("interrupt granted in quasi-idle");

  a_pec_quasi: assert property (@(posedge core_clk) disable iff (reset)
    quasiIdle |-> !eventTransferGrant)
    else $error("event transfer granted in quasi-idle");

  a_pd_nogrant: assert property (@(posedge core_clk) disable iff (reset)
    powerDownMode |-> !interruptGrant && !eventTransferGrant)
    else $error("grant issued in power-down");

  a_grant_refused: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg == RUN && powerDownInstruction && !ignoreEntry) |=> !interruptGrant && !eventTransferGrant)
    else $error("grant issued on power-down entry");

endmodule : power_down_entry_control
`default_nettype wire

/* verif/wake_pin_model.sv */
// Pin model for the interrupt and port-two wake inputs.
// Assumes requests change just after core_clk rises.
`timescale 1ns/1ps
`default_nettype none
`include "power_down_entry_defs.svh"
module wake_pin_model (
  // Requests
  input wire logic nmiAssert,
  input wire logic [`WAKE_PIN_COUNT-1:0] wakeDrive,
  // Pins
  output logic nmiPin,
  output logic [`WAKE_PIN_COUNT-1:0] wakePins
);
  // Pin is active low, so idle reads high
  assign nmiPin = ~nmiAssert;
  assign wakePins = wakeDrive;
endmodule : wake_pin_model
`default_nettype wire

/* verif/tb_power_down_entry_control.sv */
// Random bench for power_down_entry_control.
// Assumes defs header, package and pin model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "power_down_entry_defs.svh"
module tb_power_down_entry_control;
  import power_down_entry_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, strobe = 1'b0, prevWr = 1'b0, nextExt = 1'b0;
  logic wdg = 1'b0, irq = 1'b0, evt = 1'b0, nmiAssert = 1'b0;
  logic [`WAKE_PIN_COUNT-1:0] wakeDrive = 8'h00;
  wire nmiPin;
  wire [`WAKE_PIN_COUNT-1:0] wakePins;
  wire [5:0] seen;
  pd_config_t cfg = 19'h00000;
  logic [5:0] q[$];
  logic [31:0] rng = 32'h00010375;
  int fails = 0, testsRun = 0, cyc = 0;
  event got;
  ////////////////////////////////////////////////////////////////
  initial forever #4 core_clk = ~core_clk;
  wake_pin_model u_pins (.nmiAssert(nmiAssert), .wakeDrive(wakeDrive), .nmiPin(nmiPin), .wakePins(wakePins));
  power_down_entry_control u_dut (.core_clk(core_clk), .reset(reset), .powerDownInstruction(strobe),
    .prevExternalWrite(prevWr), .nextCodeExternal(nextExt), .sysConfig(cfg), .nmiPin(nmiPin),
    .wakePins(wakePins), .watchdogOverflow(wdg), .interruptRequest(irq), .eventTransferRequest(evt),
    .powerDownMode(seen[5]), .quasiIdle(seen[4]), .fetchEnable(seen[3]), .interruptGrant(seen[2]),
    .eventTransferGrant(seen[1]), .watchdogReset(seen[0]));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nextRand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : nextRand
  // Notes land at the falling edge so registered outputs have settled
  task automatic note(input logic [5:0] v);
    @(negedge core_clk);
    q.push_back(v);
    -> got;
  endtask : note
  task automatic testDone();
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : testDone
  task automatic trial();
    pd_config_t c;
    logic [31:0] r;
    logic ign, qi, run;
    r = nextRand();
    c = r[18:0];
    r = nextRand();
    // Thin the enables so port-two entries also happen
    c.wakeEnable = c.wakeEnable & r[23:16] & r[31:24];
    ign = c.wakeSourceSelect ? |(c.wakeEnable & ~(r[7:0] ^ c.wakeActiveHigh)) : !r[8];
    qi = ign & r[10] & ((c.multiplexedBus & (c.memoryTristateWaitBit == `WAIT_BIT_TRISTATE)) | r[9]);
    run = ign & !qi;
    @(posedge core_clk);
    cfg <= c;
    wakeDrive <= r[7:0];
    nmiAssert <= !c.wakeSourceSelect & r[8];
    prevWr <= r[9];
    nextExt <= r[10];
    strobe <= 1'b1;
    @(posedge core_clk);
    strobe <= 1'b0;
    irq <= 1'b1;
    evt <= 1'b1;
    note({!ign, qi, run, 3'b000});
    @(posedge core_clk);
    note({!ign, qi, run, run, run, 1'b0});
    @(posedge core_clk);
    if (qi && r[11]) begin
      wdg <= 1'b1;
      @(posedge core_clk);
      wdg <= 1'b0;
      note(6'b010001);
      @(posedge core_clk);
      note(6'b001000);
      @(posedge core_clk);
      note(6'b001110);
    end else if (qi) begin
      nmiAssert <= 1'b1;
      @(posedge core_clk);
      note(6'b100000);
    end
    @(posedge core_clk);
    reset <= 1'b1;
    {irq, evt, nmiAssert} <= 3'b000;
    @(posedge core_clk);
    reset <= 1'b0;
    note(6'b001000);
  endtask : trial
  ////////////////////////////////////////////////////////////////
  initial forever begin
    @(got);
    testsRun++;
    if (seen !== q[0]) begin
      fails++;
      $display("wrong value status expected %b seen %b", q[0], seen);
    end
    void'(q.pop_front());
  end
  // Sixty trials need well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      testDone();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    repeat (60) trial();
    testDone();
  end
endmodule : tb_power_down_entry_control
`default_nettype wire
